// >>> include/sar_defs.svh
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH
`define SAR_RESULT_BITS 10
`define SAR_UPPER_BITS 8
`define SAR_LOWER_BITS 2
`define SAR_CLK_PERIOD_PS 4000
`define SAR_RESET_TIME_PS 1500000
`define SAR_RESET_CYCLES ((`SAR_RESET_TIME_PS) / (`SAR_CLK_PERIOD_PS))
`define SAR_STEP_CYCLES_DEF 4
`define SAR_DONE_IDLE_RST 1'b1
`endif

// >>> include/sar_pkg.sv
`default_nettype none
package sar_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_SEARCH
  } conv_state_t;

  typedef struct packed {
    logic [7:0] upper;
    logic [1:0] lower;
  } result_bus_t;

  typedef struct packed {
    logic [7:0] upper_oe;
    logic [1:0] lower_oe;
  } result_oe_t;
endpackage : sar_pkg
`default_nettype wire

// >>> verilog/sar_step_timer.sv
`default_nettype none
`include "sar_defs.svh"
module sar_step_timer
  import sar_pkg::*;
#(
  parameter int STEP_CYCLES = `SAR_STEP_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);
  localparam int CW = $clog2(STEP_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(STEP_CYCLES - 1);
  logic [CW-1:0] count_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else if (!run || count_ff == LAST) begin
      count_ff <= '0;
    end else begin
      count_ff <= count_ff + CW'(1);
    end
  end

  assign tick = run && (count_ff == LAST);
endmodule : sar_step_timer
`default_nettype wire

// >>> verilog/sar_adc_conversion_control.sv
// Overview of operation
// RL1: Host holds start_pulse high at least 500 ns before releasing it.
// RL2: Done line goes high within 1.5 us of start_pulse rising edge.
// RL3: Conversion proper begins on the falling edge of start_pulse.
// RL4: Ten bits tried MSB first; a bit is cleared when sum exceeds input.
// RL5: Done line driven low once all bits are decided.
// RL6: Upper 8 and lower 2 result bits enabled separately by host.
// RL7: Host returns both enables high before the next conversion.
// RL8: Bipolar range adds offset of MSB weight minus half an LSB.
// RL9: Range select tied low gives unipolar, otherwise bipolar.
// RL10: Unipolar codes plain binary, bipolar codes offset binary.
// RL11: Bipolar: minus full scale all zeros, zero top bit, top all ones.
// RL12: Completed result held until the next start pulse.
// RL13: One result bit decided per step of the internal clock.
`default_nettype none
`include "sar_defs.svh"
module sar_adc_conversion_control
  import sar_pkg::*;
#(
  parameter int BITS = `SAR_RESULT_BITS,
  parameter int STEP_CYCLES = `SAR_STEP_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start_pulse,
  input wire logic range_select,
  input wire logic upper_byte_enable_n,
  input wire logic lower_byte_enable_n,
  input wire logic [BITS-1:0] analog_level,
  output logic [BITS-1:0] dac_trial,
  output logic bipolar_offset_on,
  output logic conversion_done_n_out,
  output logic conversion_done_n_oe,
  output result_bus_t data_out,
  output result_oe_t data_oe
);
  localparam int SEL_W = $clog2(BITS + 1);

  conv_state_t state_ff;
  logic start_d_ff;
  logic [BITS-1:0] trial_ff;
  logic [BITS-1:0] result_ff;
  logic [SEL_W-1:0] bit_ff;
  logic done_n_ff;
  logic bip_ff;
  logic tick;
  logic rise;
  logic fall;
  logic [BITS-1:0] keep;
  logic search_end;
  logic [`SAR_UPPER_BITS-1:0] nxt_upper_oe;
  logic [`SAR_LOWER_BITS-1:0] nxt_lower_oe;

  // Bit mask for the position under test.
  function automatic logic [BITS-1:0] bit_mask(input logic [SEL_W-1:0] idx);
    bit_mask = '0;
    bit_mask[idx] = 1'b1;
  endfunction : bit_mask

  assign rise = start_pulse && !start_d_ff;
  assign fall = !start_pulse && start_d_ff;

  // The sampled level is already offset for bipolar, so one compare serves
  // both ranges and the offset-binary coding falls out directly.
  assign keep = (trial_ff > analog_level) ? (trial_ff & ~bit_mask(bit_ff))
                                          : trial_ff; // [RL4] [RL10] [RL11]

  // Result and done both key off this one term, so the done line can never
  // fall a cycle before the result it announces has been latched.
  assign search_end = (state_ff == ST_SEARCH) && tick && (bit_ff == '0);

  // The step timer stands in for the internal free-running clock. It counts
  // only while a search runs, so every bit gets the same settling time.
  sar_step_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .run(state_ff == ST_SEARCH),
    .tick(tick)
  );

  // Inputs are synchronous, so one stage serves to find both edges. It resets
  // low, the idle level of the pin, so no false edge follows reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      start_d_ff <= 1'b0;
    end else begin
      start_d_ff <= start_pulse;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bip_ff <= 1'b0;
    end else begin
      bip_ff <= range_select; // [RL9] [RL8]
    end
  end

  // A new rising edge aborts any search in progress; RL1 keeps the pulse
  // long enough that the reset is always seen well before the falling edge.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      bit_ff <= '0;
      trial_ff <= '0;
    end else if (rise) begin
      state_ff <= ST_ARMED; // [RL2]
      bit_ff <= '0;
      trial_ff <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          state_ff <= ST_IDLE;
        end
        ST_ARMED: begin
          if (fall) begin
            state_ff <= ST_SEARCH; // [RL3]
            bit_ff <= SEL_W'(BITS - 1);
            trial_ff <= bit_mask(SEL_W'(BITS - 1));
          end
        end
        ST_SEARCH: begin
          if (tick) begin // [RL13]
            if (bit_ff == '0) begin
              state_ff <= ST_IDLE;
              trial_ff <= keep;
            end else begin
              bit_ff <= bit_ff - SEL_W'(1);
              trial_ff <= keep | bit_mask(bit_ff - SEL_W'(1)); // [RL4]
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_ff <= '0;
    end else if (rise) begin
      result_ff <= '0;
    end else if (search_end) begin
      result_ff <= keep; // [RL12]
    end
  end

  // Done is released within two cycles of the rising edge, far inside 1.5 us.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_n_ff <= `SAR_DONE_IDLE_RST;
    end else if (rise) begin
      done_n_ff <= 1'b1; // [RL2]
    end else if (search_end) begin
      done_n_ff <= 1'b0; // [RL5]
    end
  end

  // The done line is open drain: its pad value stays low and only the enable
  // moves, so the released level comes from the pull-up on the line.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conversion_done_n_out <= 1'b0;
    end else begin
      conversion_done_n_out <= 1'b0; // [RL5]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conversion_done_n_oe <= 1'b0;
    end else begin
      conversion_done_n_oe <= !done_n_ff; // [RL2] [RL5]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dac_trial <= '0;
    end else begin
      dac_trial <= trial_ff; // [RL4]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bipolar_offset_on <= 1'b0;
    end else begin
      bipolar_offset_on <= bip_ff; // [RL8]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= '0;
    end else begin
      data_out.upper <= result_ff[`SAR_LOWER_BITS +: `SAR_UPPER_BITS]; // [RL6]
      data_out.lower <= result_ff[0 +: `SAR_LOWER_BITS]; // [RL12]
    end
  end

  // Buffers may be enabled at any time; the host is expected to read only
  // after done falls and to release both enables before a new start.
  // Each buffer bit follows the enable of its own byte.
  for (genvar g = 0; g < `SAR_UPPER_BITS; g++) begin : g_upper_oe
    assign nxt_upper_oe[g] = !upper_byte_enable_n; // [RL6]
  end
  for (genvar g = 0; g < `SAR_LOWER_BITS; g++) begin : g_lower_oe
    assign nxt_lower_oe[g] = !lower_byte_enable_n; // [RL6]
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_oe <= '0;
    end else begin
      data_oe.upper_oe <= nxt_upper_oe; // [RL6]
      data_oe.lower_oe <= nxt_lower_oe; // [RL6]
    end
  end
endmodule : sar_adc_conversion_control
`default_nettype wire

// >>> test/sar_host_model.sv
`default_nettype none
module sar_host_model (
  input wire logic clock,
  output logic start_pulse,
  output logic upper_byte_enable_n,
  output logic lower_byte_enable_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    start_pulse = 1'b0;
    upper_byte_enable_n = 1'b1;
    lower_byte_enable_n = 1'b1;
  end
  task automatic convert(input int n);
    @(negedge clock);
    start_pulse = 1'b1;
    repeat (n) @(negedge clock);
    start_pulse = 1'b0;
  endtask : convert
  task automatic enable(input logic u, input logic l);
    @(negedge clock);
    upper_byte_enable_n = u;
    lower_byte_enable_n = l;
  endtask : enable
endmodule : sar_host_model
`default_nettype wire

// >>> test/sar_adc_properties.sv
`default_nettype none
module sar_adc_properties
  import sar_pkg::*;
#(
  parameter int BITS = 10,
  parameter int STEP_CYCLES = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start_pulse,
  input wire logic range_select,
  input wire logic upper_byte_enable_n,
  input wire logic lower_byte_enable_n,
  input wire logic [BITS-1:0] dac_trial,
  input wire logic bipolar_offset_on,
  input wire logic conversion_done_n_out,
  input wire logic conversion_done_n_oe,
  input wire result_bus_t data_out,
  input wire result_oe_t data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DMIN = BITS * STEP_CYCLES;
  localparam int DMAX = DMIN + 5;
  wire logic done_oe = conversion_done_n_oe;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence rise; $rose(start_pulse); endsequence
  sequence fall; $fell(start_pulse); endsequence
  chk_done_release: assert property (
    rise |-> ##[1:3] !done_oe) else $error("no release");
  chk_no_early: assert property (
    start_pulse [*4] |-> !done_oe) else $error("early done");
  chk_msb_first: assert property (
    fall |-> ##[1:4] dac_trial == 10'h200) else $error("no msb");
  chk_search_busy: assert property (
    fall |-> !done_oe [*8]) else $error("short search");
  // A new start during the search aborts it, so that attempt is dropped.
  chk_done_time: assert property (
    disable iff (!rst_n || start_pulse)
    fall |-> ##[DMIN:DMAX] done_oe) else $error("no done");
  chk_done_held: assert property (
    done_oe && !start_pulse |=> done_oe) else $error("done lost");
  chk_result_held: assert property (
    done_oe && !start_pulse |=> $stable(data_out)) else $error("data lost");
  chk_drain_low: assert property (
    conversion_done_n_out == 1'b0) else $error("done driven high");
  chk_byte_enable: assert property (
    done_oe |=> data_oe == {{8{!$past(upper_byte_enable_n)}},
    {2{!$past(lower_byte_enable_n)}}}) else $error("bad enable");
  chk_range_sel: assert property (
    $past(rst_n, 2) |-> bipolar_offset_on == $past(range_select, 2))
    else $error("bad range");
endmodule : sar_adc_properties
bind sar_adc_conversion_control sar_adc_properties #(
  .BITS(BITS),
  .STEP_CYCLES(STEP_CYCLES)
) u_props (
  .clock(clock),
  .rst_n(rst_n),
  .start_pulse(start_pulse),
  .range_select(range_select),
  .upper_byte_enable_n(upper_byte_enable_n),
  .lower_byte_enable_n(lower_byte_enable_n),
  .dac_trial(dac_trial),
  .bipolar_offset_on(bipolar_offset_on),
  .conversion_done_n_out(conversion_done_n_out),
  .conversion_done_n_oe(conversion_done_n_oe),
  .data_out(data_out),
  .data_oe(data_oe)
);
`default_nettype wire

// >>> test/sar_adc_conversion_control_tb_top.sv
`default_nettype none
module sar_adc_conversion_control_tb_top
  import sar_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic range_select = 1'b0;
  logic start_pulse, upper_byte_enable_n, lower_byte_enable_n;
  logic [9:0] analog_level = 10'h000;
  logic [9:0] dac_trial;
  logic bipolar_offset_on, conversion_done_n_out, conversion_done_n_oe;
  result_bus_t data_out;
  result_oe_t data_oe;
  int err_total = 0;
  int samples_checked = 0;
  always #2 clock = ~clock;
  sar_host_model host (
    .clock(clock),
    .start_pulse(start_pulse),
    .upper_byte_enable_n(upper_byte_enable_n),
    .lower_byte_enable_n(lower_byte_enable_n)
  );
  sar_adc_conversion_control #(
    .STEP_CYCLES(1)
  ) uut (
    .clock(clock),
    .rst_n(rst_n),
    .start_pulse(start_pulse),
    .range_select(range_select),
    .upper_byte_enable_n(upper_byte_enable_n),
    .lower_byte_enable_n(lower_byte_enable_n),
    .analog_level(analog_level),
    .dac_trial(dac_trial),
    .bipolar_offset_on(bipolar_offset_on),
    .conversion_done_n_out(conversion_done_n_out),
    .conversion_done_n_oe(conversion_done_n_oe),
    .data_out(data_out),
    .data_oe(data_oe)
  );
  task automatic cmp(input string s, input logic [9:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : cmp
  task automatic conv(input logic [9:0] v, input logic r);
    analog_level = v;
    range_select = r;
    host.convert(125);
    repeat (14) @(negedge clock);
    cmp("done", 10'h001, {9'h0, conversion_done_n_oe});
    host.enable(1'b0, 1'b0);
    @(negedge clock);
    cmp("data", v, data_out);
  endtask : conv
  task automatic t_codes;
    logic [9:0] lv [5] = '{10'h000, 10'h200, 10'h3FF, 10'h155, 10'h2AA};
    for (int r = 0; r < 2; r++) begin
      foreach (lv[i]) begin
        conv(lv[i], r[0]);
        host.enable(1'b1, 1'b1);
      end
    end
    $display("t_codes done");
  endtask : t_codes
  task automatic t_split;
    conv(10'h2C3, 1'b0);
    analog_level = 10'h000;
    host.enable(1'b0, 1'b1);
    @(negedge clock);
    cmp("upper", 10'h3FC, data_oe);
    host.enable(1'b1, 1'b0);
    @(negedge clock);
    cmp("lower", 10'h003, data_oe);
    cmp("hold", 10'h2C3, data_out);
    host.enable(1'b1, 1'b1);
    $display("t_split done");
  endtask : t_split
  // A second start a few steps into a search must abort it and restart.
  task automatic t_abort;
    analog_level = 10'h0F0;
    host.convert(125);
    repeat (3) @(negedge clock);
    conv(10'h1E1, 1'b0);
    host.enable(1'b1, 1'b1);
    $display("t_abort done");
  endtask : t_abort
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    t_codes();
    t_split();
    t_abort();
    end_of_test();
  end
  // Thirteen starts of about 150 cycles each fit well inside this span.
  initial begin
    #20000;
    err_total++;
    end_of_test();
  end
endmodule : sar_adc_conversion_control_tb_top
`default_nettype wire
